//--- tb/sfwi_core_tb.sv
`timescale 1ns/1ps
module sfwi_core_tb;
    import sfwi_pkg::*;
    typedef struct {
        logic       sl;
        logic       bz;
        logic [7:0] op;
        logic       id;
        logic       slp;
        logic       stb;
    } sfwi_row_t;
    logic       clk, sys_rst, cycle_busy, wel_set, wel_clr, sleep_enter;
    logic       sclk, cs_n, mosi, miso, miso_oe_n, miso_line;
    logic       in_deep_sleep, in_standby, write_locked, cmd_strobe;
    logic [7:0] status_flags, cmd_code, array_init_data, rd;
    logic       stb, drv;
    int         bad_count, cmp_count, n;
    sfwi_row_t  rows [8];
    sfwi_core #(.UNLOCK_CYC(2000)) sfwi_core_inst (
        .clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .cycle_busy(cycle_busy), .wel_set(wel_set),
        .wel_clr(wel_clr), .sleep_enter(sleep_enter), .miso(miso),
        .miso_oe_n(miso_oe_n), .status_flags(status_flags),
        .in_deep_sleep(in_deep_sleep), .in_standby(in_standby),
        .write_locked(write_locked), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .array_init_data(array_init_data)
    );
    sfwi_host sfwi_host_inst (
        .clk(clk), .miso(miso_line), .sclk(sclk), .cs_n(cs_n), .mosi(mosi)
    );
    // Undriven output line shows the inverse so a late enable is caught
    assign miso_line = miso_oe_n ? ~miso : miso;
    always #20 clk = ~clk;
    always @(posedge clk) begin
        if (cmd_strobe === 1'b1) stb = 1'b1;
        if (miso_oe_n === 1'b0) drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] op, input int nout);
        stb = 1'b0;
        drv = 1'b0;
        sfwi_host_inst.xfer(op, (op == WAKE_OPCODE_DEF) ? 24 : 0, nout, 4, rd);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        conclude();
    end
    initial begin
        rows[0] = '{1'b0, 1'b0, WAKE_OPCODE_DEF, 1'b1, 1'b0, 1'b0};
        rows[1] = '{1'b1, 1'b0, PROG_OPCODE_DEF, 1'b0, 1'b1, 1'b0};
        rows[2] = '{1'b1, 1'b1, WAKE_OPCODE_DEF, 1'b0, 1'b1, 1'b0};
        rows[3] = '{1'b0, 1'b0, WAKE_OPCODE_DEF, 1'b1, 1'b0, 1'b0};
        rows[4] = '{1'b0, 1'b0, PROG_OPCODE_DEF, 1'b0, 1'b0, 1'b1};
        rows[5] = '{1'b0, 1'b0, BLKW_OPCODE_DEF, 1'b0, 1'b0, 1'b1};
        rows[6] = '{1'b0, 1'b0, FULLW_OPCODE_DEF, 1'b0, 1'b0, 1'b1};
        rows[7] = '{1'b0, 1'b0, STWR_OPCODE_DEF, 1'b0, 1'b0, 1'b1};
        clk = 1'b0;
        sys_rst = 1'b1;
        {cycle_busy, wel_set, wel_clr, sleep_enter} = 4'h0;
        bad_count = 0;
        cmp_count = 0;
        tick(8);
        check(status_flags, STATUS_RST);
        check(array_init_data, BLANK_BYTE);
        check(8'(miso_oe_n), 8'h01);
        sys_rst = 1'b0;
        tick(2);
        check(8'(in_standby), 8'h01);
        check(8'(in_deep_sleep), 8'h00);
        check(8'(write_locked), 8'h01);
        tick(250);
        $display("reset test done");
        frame(PROG_OPCODE_DEF, 0);
        check(8'(stb), 8'h00);
        frame(8'h03, 0);
        check(8'(stb), 8'h01);
        check(cmd_code, 8'h03);
        n = 0;
        while (write_locked === 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        check(8'(write_locked), 8'h00);
        $display("lockout test done");
        for (int i = 0; i < 8; i++) begin
            if (rows[i].sl) pulse(sleep_enter);
            cycle_busy = rows[i].bz;
            tick(3);
            frame(rows[i].op, 2);
            check(8'(drv), 8'(rows[i].id));
            if (rows[i].id) check(rd, ID_BYTE_DEF);
            check(8'(in_deep_sleep), 8'(rows[i].slp));
            check(8'(in_standby), 8'(!rows[i].slp));
            check(8'(stb), 8'(rows[i].stb));
            if (rows[i].stb) check(cmd_code, rows[i].op);
            cycle_busy = 1'b0;
            tick(2);
            $display("row %0d done", i);
        end
        pulse(sleep_enter);
        sfwi_host_inst.xfer(WAKE_OPCODE_DEF, 0, 0, 0, rd);
        check(8'(in_deep_sleep), 8'h00);
        check(8'(in_standby), 8'h00);
        n = 0;
        while (in_standby !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        check(8'(n > 30 && n <= int'(WAKE_DELAY_NS / CLK_PERIOD_NS)), 8'h01);
        tick(4);
        $display("early end test done");
        cycle_busy = 1'b1;
        tick(2);
        check(status_flags, 8'h01);
        check(8'(in_standby), 8'h00);
        cycle_busy = 1'b0;
        pulse(wel_set);
        check(status_flags, 8'h02);
        pulse(wel_clr);
        check(status_flags, 8'h00);
        pulse(wel_set);
        pulse(sleep_enter);
        check(8'(in_deep_sleep), 8'h01);
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(2);
        check(8'(in_deep_sleep), 8'h00);
        check(8'(in_standby), 8'h01);
        check(status_flags, STATUS_RST);
        $display("status and reset test done");
        conclude();
    end
endmodule

//--- tb/sfwi_host.sv
`timescale 1ns/1ps
module sfwi_host (
    input  wire logic clk,
    input  wire logic miso,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Data set while low, device samples it at the rise
    task automatic bit_x(input logic b, output logic r);
        sclk = 1'b0;
        mosi = b;
        tick(3);
        r = miso;
        sclk = 1'b1;
        tick(2);
    endtask
    // Opcode, nd dummy bits, nout output bytes, deselect, idle gap
    task automatic xfer(input logic [7:0] op, input int nd, input int nout,
                        input int gap, output logic [7:0] rd);
        logic r;
        rd = 8'h00;
        cs_n = 1'b0;
        tick(2);
        for (int i = 7; i >= 0; i--) bit_x(op[i], r);
        for (int i = 0; i < nd; i++) bit_x(1'b0, r);
        for (int i = 0; i < 8 * nout; i++) begin
            bit_x(~mosi, r);
            rd = {rd[6:0], r};
        end
        sclk = 1'b0;
        tick(2);
        cs_n = 1'b1;
        mosi = ~mosi;
        tick(gap);
    endtask
endmodule

//--- verilog/sfwi_core.sv
`timescale 1ns/1ps
module sfwi_core
    import sfwi_pkg::*;
#(
    parameter logic [7:0]  WAKE_OPCODE = WAKE_OPCODE_DEF,
    parameter logic [7:0]  PROG_OPCODE = PROG_OPCODE_DEF,
    parameter logic [7:0]  BLKW_OPCODE = BLKW_OPCODE_DEF,
    parameter logic [7:0]  FULLW_OPCODE = FULLW_OPCODE_DEF,
    parameter logic [7:0]  STWR_OPCODE = STWR_OPCODE_DEF,
    parameter logic [7:0]  ID_BYTE     = ID_BYTE_DEF,
    parameter int unsigned UNLOCK_CYC  = UNLOCK_CYC_DEF
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    input  wire logic       cycle_busy,
    input  wire logic       wel_set,
    input  wire logic       wel_clr,
    input  wire logic       sleep_enter,
    output logic            miso,
    output logic            miso_oe_n,
    output logic [7:0]      status_flags,
    output logic            in_deep_sleep,
    output logic            in_standby,
    output logic            write_locked,
    output logic            cmd_strobe,
    output logic [7:0]      cmd_code,
    output logic [7:0]      array_init_data
);
    sfwi_pwr_t  pwr_r;
    sfwi_pwr_t  pwr_nxt;
    sfwi_frm_t  frm_r;
    sfwi_frm_t  frm_nxt;
    logic [7:0] shift_r;
    logic [4:0] bit_cnt_r;
    logic [2:0] out_idx_r;
    logic       sig_done_r;
    logic       wait_r;
    logic       miso_r;
    logic       oe_n_r;
    logic [7:0] status_r;
    logic       sleep_r;
    logic       standby_r;
    logic       locked_r;
    logic       cmd_strobe_r;
    logic [7:0] cmd_code_r;
    logic [7:0] array_init_r;

    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;
    logic       cs_fall;
    logic       wake_busy;
    logic       lock_busy;
    logic [7:0] opc_full;
    logic       wr_busy;
    logic       opc_last;
    logic       is_wake;
    logic       is_write_cls;
    logic       dec_wake;
    logic       dec_other;
    logic       cmd_ok;
    logic       dummy_last;
    logic       sig_shift;
    logic       sig_bit;
    logic       wake_start;
    logic       wake_now;
    logic       wake_end;

    sfwi_edge #(.INIT(1'b0)) u_sclk_edge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (sclk),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );

    // Select starts low-seen so a level low at release does not count as a fall
    sfwi_edge #(.INIT(1'b0)) u_cs_edge (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     (cs_n),
        .rise    (cs_rise),
        .fall    (cs_fall)
    );

    // Two clocks of select sampling and state update come off the count
    sfwi_timer #(.W(TW), .RST_CNT('0)) u_wake_tmr (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (wake_start),
        .load    (WAKE_CYC - TW'(2)), // RULE13
        .busy    (wake_busy)
    );

    // Lockout runs from supply reset release
    sfwi_timer #(.W(TW), .RST_CNT(TW'(UNLOCK_CYC))) u_lock_tmr (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (1'b0),
        .load    ('0),
        .busy    (lock_busy)
    );

    // Decode terms
    assign opc_full     = {shift_r[6:0], mosi};
    assign wr_busy      = status_r[WR_BUSY_BIT];
    assign opc_last     = (frm_r == FRM_OPCODE) && sclk_rise && (bit_cnt_r == OPC_LAST_BIT); // RULE6
    assign is_wake      = (opc_full == WAKE_OPCODE); // RULE22
    assign is_write_cls = (opc_full == PROG_OPCODE) || (opc_full == BLKW_OPCODE) ||
                          (opc_full == FULLW_OPCODE) || (opc_full == STWR_OPCODE);
    assign dec_wake     = opc_last && is_wake && !wr_busy; // RULE4 RULE5
    assign dec_other    = opc_last && !is_wake && (pwr_r == PWR_STANDBY); // RULE1
    assign cmd_ok       = dec_other && !(is_write_cls && locked_r); // RULE15
    assign dummy_last   = (frm_r == FRM_DUMMY) && sclk_rise && (bit_cnt_r == DUMMY_LAST_BIT);
    assign sig_shift    = (frm_r == FRM_SIG) && sclk_fall && !cs_n; // RULE7
    assign sig_bit      = ID_BYTE[out_idx_r]; // RULE3
    assign wake_start   = cs_rise && (pwr_r == PWR_WAKING) && !wait_r && !sig_done_r; // RULE11
    assign wake_now     = cs_rise && (pwr_r == PWR_WAKING) && !wait_r && sig_done_r; // RULE10
    assign wake_end     = wait_r && !wake_busy; // RULE13

    // Frame sequencing
    always_comb begin
        frm_nxt = frm_r;
        if (cs_n) begin
            frm_nxt = FRM_IDLE; // RULE10
        end else begin
            unique case (frm_r)
                FRM_IDLE: begin
                    if (cs_fall) begin
                        frm_nxt = (pwr_r == PWR_WAKING) ? FRM_OTHER : FRM_OPCODE;
                    end
                end
                FRM_OPCODE: begin
                    if (opc_last) begin
                        frm_nxt = dec_wake ? FRM_DUMMY : FRM_OTHER; // RULE1 RULE5
                    end
                end
                FRM_DUMMY: begin
                    if (dummy_last) begin
                        frm_nxt = FRM_SIG;
                    end
                end
                FRM_SIG:   frm_nxt = FRM_SIG; // RULE8
                FRM_OTHER: frm_nxt = FRM_OTHER;
            endcase
        end
    end

    // Power mode
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_STANDBY: begin
                if (sleep_enter && !wr_busy) begin
                    pwr_nxt = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (dec_wake) begin
                    pwr_nxt = PWR_WAKING; // RULE2
                end
            end
            PWR_WAKING: begin
                if (wake_now || wake_end) begin
                    pwr_nxt = PWR_STANDBY; // RULE10 RULE11
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin // RULE14
            pwr_r <= PWR_STANDBY; // RULE19
            frm_r <= FRM_IDLE;
            wait_r <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            frm_r <= frm_nxt;
            wait_r <= wake_start | (wait_r & ~wake_end);
        end
    end

    // Serial input and counters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift_r <= 8'h00;
            bit_cnt_r <= 5'h00;
        end else begin
            if (sclk_rise && frm_r == FRM_OPCODE) begin
                shift_r <= opc_full; // RULE6
            end
            if (cs_fall || opc_last) begin
                bit_cnt_r <= 5'h00;
            end else if (sclk_rise && (frm_r == FRM_OPCODE || frm_r == FRM_DUMMY)) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // Identity output; index wraps so the byte repeats
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_idx_r <= SIG_FIRST_IDX;
            sig_done_r <= 1'b0;
            miso_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            if (cs_n) begin
                out_idx_r <= SIG_FIRST_IDX;
                oe_n_r <= 1'b1;
            end else if (sig_shift) begin
                out_idx_r <= out_idx_r - 3'h1; // RULE8
                miso_r <= sig_bit; // RULE7
                oe_n_r <= 1'b0;
            end
            if (cs_fall) begin
                sig_done_r <= 1'b0;
            end else if (sig_shift && out_idx_r == 3'h0) begin
                sig_done_r <= 1'b1;
            end
        end
    end

    // Status flags: busy mirrors the cycle, latch set wins over clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_r <= STATUS_RST; // RULE19 RULE20
        end else begin
            status_r[WR_BUSY_BIT] <= cycle_busy; // RULE21
            status_r[WR_LATCH_BIT] <= wel_set | (status_r[WR_LATCH_BIT] & ~wel_clr);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sleep_r <= 1'b0;
            standby_r <= 1'b0;
            locked_r <= 1'b1;
            cmd_strobe_r <= 1'b0;
            cmd_code_r <= 8'h00;
            array_init_r <= BLANK_BYTE; // RULE20
        end else begin
            sleep_r <= (pwr_nxt == PWR_SLEEP);
            standby_r <= (pwr_nxt == PWR_STANDBY) && !cycle_busy;
            locked_r <= lock_busy; // RULE15
            cmd_strobe_r <= cmd_ok;
            if (cmd_ok) begin
                cmd_code_r <= opc_full;
            end
            array_init_r <= BLANK_BYTE;
        end
    end

    assign miso            = miso_r;
    assign miso_oe_n       = oe_n_r;
    assign status_flags    = status_r;
    assign in_deep_sleep   = sleep_r;
    assign in_standby      = standby_r;
    assign write_locked    = locked_r;
    assign cmd_strobe      = cmd_strobe_r;
    assign cmd_code        = cmd_code_r;
    assign array_init_data = array_init_r;

    chk_sleep_ignore: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        (opc_last && pwr_r == PWR_SLEEP && !is_wake) |=> (!cmd_strobe && frm_r == FRM_OTHER))
        else $error("Instruction accepted in deep sleep");

    chk_wake_exit: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        (opc_last && is_wake && !wr_busy && pwr_r == PWR_SLEEP) |=> (pwr_r == PWR_WAKING))
        else $error("Wake opcode did not leave deep sleep");

    chk_busy_block: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        (opc_last && is_wake && wr_busy && !cs_n) |=> (frm_r == FRM_OTHER && $stable(pwr_r)))
        else $error("Wake opcode decoded during busy cycle");

    chk_dummy_count: assert property (@(posedge clk) disable iff (sys_rst) // RULE6
        (dummy_last && !cs_n) |=> (frm_r == FRM_SIG && miso_oe_n))
        else $error("Dummy address length wrong");

    chk_sig_bit: assert property (@(posedge clk) disable iff (sys_rst) // RULE7
        sig_shift |=> (miso == $past(sig_bit) && !miso_oe_n))
        else $error("Identity bit wrong on output");

    chk_sig_repeat: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        (sig_shift && out_idx_r == 3'h0) |=> (out_idx_r == SIG_FIRST_IDX && sig_done_r))
        else $error("Identity byte did not wrap");

    chk_end_standby: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        wake_now |=> (pwr_r == PWR_STANDBY && frm_r == FRM_IDLE && miso_oe_n))
        else $error("Select high did not give standby");

    chk_early_wake: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        wake_start |-> (pwr_r == PWR_WAKING)[*2] ##[1:39] (pwr_r == PWR_STANDBY))
        else $error("Early end did not reach standby in wake delay");

    chk_lock_cmd: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
        (dec_other && is_write_cls && locked_r) |=> !cmd_strobe)
        else $error("Write-class opcode passed during lockout");

    chk_reset_state: assert property (@(posedge clk) // RULE19
        $fell(sys_rst) |-> (pwr_r == PWR_STANDBY && status_r == STATUS_RST && locked_r))
        else $error("Wrong state after supply reset");

    chk_busy_flag: assert property (@(posedge clk) disable iff (sys_rst) // RULE21
        !$stable(cycle_busy) |=> (status_flags[WR_BUSY_BIT] == $past(cycle_busy)))
        else $error("Busy flag does not follow cycle");
endmodule

//--- verilog/sfwi_edge.sv
`timescale 1ns/1ps
module sfwi_edge #(
    parameter logic INIT = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      rise,
    output logic      fall
);
    logic prev_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_r <= INIT;
        end else begin
            prev_r <= din;
        end
    end

    assign rise = din & ~prev_r;
    assign fall = ~din & prev_r;
endmodule

//--- verilog/sfwi_pkg.sv
// Functional notes
// [RULE1] Deep sleep ignores all but wake-and-identify
// [RULE2] Wake-and-identify leaves deep sleep
// [RULE3] Holds 8-bit identity byte for output
// [RULE4] Identity returned when idle, even awake
// [RULE5] Not decoded while internal cycle busy
// [RULE6] Opcode then three dummy bytes, rising edges
// [RULE7] Identity shifted out on falling edges
// [RULE8] Identity repeats while clocking continues
// [RULE9] Host raises select after one identity byte
// [RULE10] Select high ends instruction, enters standby
// [RULE11] Early end still wakes, after wake delay
// [RULE12] Host waits maximum wake delay after early end
// [RULE13] Wake delay at most 1.6 us
// [RULE14] Supply reset holds logic, answers nothing
// [RULE15] Write-class opcodes ignored during write lockout
// [RULE16] Host waits 10 us before any instruction
// [RULE17] Host delays writes until both waits expire
// [RULE18] Host keeps select inactive during power ramps
// [RULE19] Power-up in standby, write latch cleared
// [RULE20] Delivered array FFh, status 00h
// [RULE21] Busy bit set during self-timed cycles
// [RULE22] Wake opcode is a configurable parameter
package sfwi_pkg;
    localparam int unsigned CLK_PERIOD_NS    = 40;
    localparam int unsigned WAKE_DELAY_NS    = 1600;
    localparam int unsigned UNLOCK_DELAY_US  = 15000;
    localparam int unsigned SELECT_WAIT_US   = 10;
    localparam int unsigned TW               = 19;
    localparam logic [TW-1:0] WAKE_CYC       = TW'(WAKE_DELAY_NS / CLK_PERIOD_NS);
    localparam int unsigned UNLOCK_CYC_DEF   = (UNLOCK_DELAY_US * 1000) / CLK_PERIOD_NS;

    // Opcode and identity defaults are arbitrary values
    localparam logic [7:0] WAKE_OPCODE_DEF   = 8'h5a;
    localparam logic [7:0] PROG_OPCODE_DEF   = 8'h12;
    localparam logic [7:0] BLKW_OPCODE_DEF   = 8'h34;
    localparam logic [7:0] FULLW_OPCODE_DEF  = 8'h56;
    localparam logic [7:0] STWR_OPCODE_DEF   = 8'h78;
    localparam logic [7:0] ID_BYTE_DEF       = 8'h3c;

    localparam int unsigned WR_BUSY_BIT      = 0;
    localparam int unsigned WR_LATCH_BIT     = 1;
    localparam logic [7:0] STATUS_RST        = 8'h00;
    localparam logic [7:0] BLANK_BYTE        = 8'hff;
    localparam logic [4:0] OPC_LAST_BIT      = 5'h07;
    localparam logic [4:0] DUMMY_LAST_BIT    = 5'h17;
    localparam logic [2:0] SIG_FIRST_IDX     = 3'h7;

    typedef enum logic [1:0] {PWR_STANDBY, PWR_SLEEP, PWR_WAKING} sfwi_pwr_t;
    typedef enum logic [2:0] {FRM_IDLE, FRM_OPCODE, FRM_DUMMY, FRM_SIG, FRM_OTHER} sfwi_frm_t;
endpackage

//--- verilog/sfwi_timer.sv
`timescale 1ns/1ps
module sfwi_timer #(
    parameter int unsigned W       = 19,
    parameter logic [W-1:0] RST_CNT = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         start,
    input  wire logic [W-1:0] load,
    output logic              busy
);
    logic [W-1:0] cnt_r;

    // Down counter; busy while non-zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= RST_CNT;
        end else if (start) begin
            cnt_r <= load;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign busy = (cnt_r != '0);
endmodule
